// File: hdl/dlt_pkg.sv
// constants and carrier types for the data link transparent match block
package dlt_pkg;
  // register word indexes; byte address is four times the index
  localparam logic [3:0] REG_LINK_CONTROL   = 4'h1;
  localparam logic [3:0] REG_TX_IDLE_CHAR   = 4'h5;
  localparam logic [3:0] REG_RX_MATCH_CHAR  = 4'h8;
  localparam logic [3:0] REG_TRANSP_CONTROL = 4'h9;
  localparam int unsigned ADDR_LSB = 2;

  // field positions
  localparam int unsigned RX_ENABLE_BIT  = 2;
  localparam int unsigned OFFSET_LSB     = 0;
  localparam int unsigned MATCH_FOUND_BIT = 3;
  localparam int unsigned ALIGNED_BIT    = 4;
  localparam int unsigned MATCH_EN_BIT   = 5;
  localparam int unsigned TRANSP_BIT     = 6;

  // reset values and other fixed constants
  localparam logic [7:0] MATCH_CHAR_RESET = 8'h7E;
  localparam logic [7:0] IDLE_CHAR_RESET  = 8'hFF;
  localparam logic [7:0] ONES_IDLE        = 8'hFF;
  localparam logic [2:0] CTRL_RESET       = 3'h0;
  localparam logic       RX_ENABLE_RESET  = 1'b0;
  localparam logic [2:0] BYTE_ALIGNED     = 3'h7;
  localparam logic [2:0] LAST_BIT         = 3'h7;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

  typedef enum logic [1:0] {
    DLT_IDLE   = 2'b00,
    DLT_HUNT   = 2'b01,
    DLT_LOCKED = 2'b11
  } dlt_state_t;

  typedef struct packed {
    logic transparent;
    logic matchEn;
    logic aligned;
  } dlt_ctrl_t;

  typedef struct packed {
    logic       matchFound;
    logic [2:0] offset;
  } dlt_status_t;
endpackage

// File: hdl/dlt_rx_hunt.sv
// receive match hunter: octet reference, match search, byte assembly
`timescale 1ns/1ps
module dlt_rx_hunt (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                bitStrobe,
  input  wire logic                bitIn,
  input  wire logic                runEnable,
  input  wire dlt_pkg::dlt_ctrl_t  ctrl,
  input  wire logic [7:0]          matchChar,
  output      logic [7:0]          byteData,
  output      logic                byteWrite,
  output      dlt_pkg::dlt_status_t status
);
  import dlt_pkg::*;

  dlt_state_t state;
  logic [7:0] shiftReg;
  logic [2:0] bitPos;
  logic [2:0] lockCount;
  logic       filled;

  // first bit received lands in bit 7 and drifts down to bit 0
  wire [7:0] next_shift = {bitIn, shiftReg[7:1]};
  wire       onBoundary = (bitPos == LAST_BIT);
  // sliding search waits for a full window so stale zeros never match
  wire       charHit    = (next_shift == matchChar) && (filled || onBoundary)
                          && (!ctrl.aligned || onBoundary);
  wire       huntHit    = ctrl.matchEn ? charHit : onBoundary;
  wire [2:0] hitOffset  = onBoundary ? BYTE_ALIGNED : bitPos;

  always_ff @(posedge clk) begin
    byteWrite <= 1'b0;
    if (!reset_n || !runEnable) begin
      state     <= DLT_IDLE;
      shiftReg  <= 8'h00;
      bitPos    <= 3'h0;
      lockCount <= 3'h0;
      filled    <= 1'b0;
      byteData  <= 8'h00;
      status    <= '0;
    end else begin
      case (state)
        DLT_IDLE: begin
          state  <= DLT_HUNT;
          bitPos <= 3'h0;
        end
        DLT_HUNT: begin
          if (bitStrobe) begin
            shiftReg <= next_shift;
            bitPos   <= bitPos + 3'h1;
            if (onBoundary) begin
              filled <= 1'b1;
            end
            if (huntHit) begin
              state             <= DLT_LOCKED;
              byteData          <= next_shift;
              byteWrite         <= 1'b1;
              status.matchFound <= 1'b1;
              status.offset     <= hitOffset;
              lockCount         <= 3'h0;
            end
          end
        end
        DLT_LOCKED: begin
          if (bitStrobe) begin
            shiftReg  <= next_shift;
            bitPos    <= bitPos + 3'h1;
            lockCount <= lockCount + 3'h1;
            if (lockCount == LAST_BIT) begin
              byteData  <= next_shift;
              byteWrite <= 1'b1;
            end
          end
        end
        default: state <= DLT_IDLE;
      endcase
    end
  end
endmodule // dlt_rx_hunt

// File: hdl/dlt_transparent_match.sv
// data link transparent mode control with match hunt and idle selection
// Contract
// - transparent mode select set means the data link unit bypasses all HDLC processing.
// - the receive match character is used only in transparent mode.
// - with pattern match enabled nothing reaches the receive FIFO before a match.
// - the matched byte is the first FIFO entry and later bytes follow it.
// - the receive match character resets to a flag and is fully writable.
// - octet aligned search compares only on octet boundaries, otherwise at every bit.
// - with pattern match disabled received data goes straight to the FIFO.
// - match found is set when the match character is recognised.
// - octet offset holds the bit offset of the match, 111 meaning byte aligned.
// - without matching, match found sets on the first byte with offset 111.
// - pattern match enabled and empty transmit FIFO sends the programmed idle character.
// - the transmit idle character resets to FF and is fully writable.
// - pattern match disabled and empty transmit FIFO sends all ones.
// - octet boundaries count from the first receive clock edge after receiver enable.
`timescale 1ns/1ps
module dlt_transparent_match (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // avalon-mm slave, byte addressed
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output      logic [31:0] readdata,
  output      logic        waitrequest,
  // line side pins
  input  wire logic        rxClkPin,
  input  wire logic        rxDataPin,
  input  wire logic        txClkPin,
  output      logic        txDataPin,
  // fifo side
  output      logic [7:0]  rxFifoData,
  output      logic        rxFifoWrite,
  input  wire logic [7:0]  txFifoData,
  input  wire logic        txFifoEmpty,
  output      logic        txFifoRead,
  output      logic        hdlcBypass
);
  import dlt_pkg::*;

  // software registers
  logic [7:0]  matchChar;
  logic [7:0]  idleChar;
  dlt_ctrl_t   ctrl;
  logic        rxEnable;
  dlt_status_t status;

  // pin synchronisers: stage 1 feeds stage 2 only
  logic [2:0]  sync1;
  logic [2:0]  sync2;
  logic [2:0]  sync3;
  logic [2:0]  settled;

  // transmit shifter
  logic [2:0]  txBitCnt;
  logic [7:0]  txShift;

  // bus decode
  wire [3:0] regIndex  = address[5:ADDR_LSB];
  wire       busReq    = read | write;
  wire       busCommit = write & ~waitrequest & byteenable[0];
  wire       hitLink   = (regIndex == REG_LINK_CONTROL);
  wire       hitIdle   = (regIndex == REG_TX_IDLE_CHAR);
  wire       hitMatch  = (regIndex == REG_RX_MATCH_CHAR);
  wire       hitTransp = (regIndex == REG_TRANSP_CONTROL);

  wire [7:0] linkView   = 8'(rxEnable) << RX_ENABLE_BIT;
  wire [7:0] transpView = {1'b0, ctrl.transparent, ctrl.matchEn, ctrl.aligned,
                           status.matchFound, status.offset};
  wire [7:0] next_read  = hitLink   ? linkView   :
                          hitIdle   ? idleChar   :
                          hitMatch  ? matchChar  :
                          hitTransp ? transpView : 8'h00;

  // a change counts once stages two and three agree
  wire [2:0] agree     = ~(sync2 ^ sync3);
  wire [2:0] next_settled = (agree & sync3) | (~agree & settled);
  wire       rxEdge    = next_settled[0] & ~settled[0];
  wire       rxBit     = next_settled[1];
  wire       txEdge    = next_settled[2] & ~settled[2];

  wire       runEnable = rxEnable & ctrl.transparent;
  wire       takeUser  = ctrl.transparent & ~txFifoEmpty;
  wire [7:0] idleByte  = ctrl.matchEn ? idleChar : ONES_IDLE;
  wire [7:0] loadByte  = takeUser ? txFifoData : idleByte;
  wire       txLoad    = (txBitCnt == 3'h0);

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
      readdata    <= READ_ZERO;
    end else begin
      waitrequest <= ~(busReq & waitrequest);
      readdata    <= {24'h00_0000, next_read};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      matchChar <= MATCH_CHAR_RESET;
      idleChar  <= IDLE_CHAR_RESET;
      ctrl      <= CTRL_RESET;
      rxEnable  <= RX_ENABLE_RESET;
    end else if (busCommit) begin
      if (hitMatch) begin
        matchChar <= writedata[7:0];
      end
      if (hitIdle) begin
        idleChar <= writedata[7:0];
      end
      if (hitLink) begin
        rxEnable <= writedata[RX_ENABLE_BIT];
      end
      // status bits and bit 7 are not writable
      if (hitTransp) begin
        ctrl.transparent <= writedata[TRANSP_BIT];
        ctrl.matchEn     <= writedata[MATCH_EN_BIT];
        ctrl.aligned     <= writedata[ALIGNED_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1   <= 3'h0;
      sync2   <= 3'h0;
      sync3   <= 3'h0;
      settled <= 3'h0;
    end else begin
      sync1   <= {txClkPin, rxDataPin, rxClkPin};
      sync2   <= sync1;
      sync3   <= sync2;
      settled <= next_settled;
    end
  end

  // the framer's hdlc engine is switched out while this is high
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hdlcBypass <= 1'b0;
    end else begin
      hdlcBypass <= ctrl.transparent;
    end
  end

  // idle fill only for whole octets; a byte is never split
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txBitCnt   <= 3'h0;
      txShift    <= ONES_IDLE;
      txDataPin  <= 1'b1;
      txFifoRead <= 1'b0;
    end else begin
      txFifoRead <= txEdge & txLoad & takeUser;
      if (txEdge) begin
        txBitCnt  <= txBitCnt + 3'h1;
        txDataPin <= txLoad ? loadByte[0] : txShift[0];
        txShift   <= txLoad ? {1'b1, loadByte[7:1]} : {1'b1, txShift[7:1]};
      end
    end
  end

  dlt_rx_hunt u_hunt (
    .clk       (clk),
    .reset_n   (reset_n),
    .bitStrobe (rxEdge),
    .bitIn     (rxBit),
    .runEnable (runEnable),
    .ctrl      (ctrl),
    .matchChar (matchChar),
    .byteData  (rxFifoData),
    .byteWrite (rxFifoWrite),
    .status    (status)
  );
endmodule // dlt_transparent_match

// File: testbench/dlt_tm_monitor.sv
// port assertions for the transparent match block
`timescale 1ns/1ps
module dlt_tm_monitor
  import dlt_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        rxFifoWrite,
  input wire logic        txFifoEmpty,
  input wire logic        txFifoRead,
  input wire logic        hdlcBypass
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire ctlAck = !waitrequest && address[5:2] == REG_TRANSP_CONTROL;
  wait_once_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer after one wait");
  ack_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("ack longer than one cycle");
  high_zero_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
    else $error("readdata high bits set");
  bypass_set_a: assert property (write && ctlAck && byteenable[0] |-> ##2
      hdlcBypass == $past(writedata[TRANSP_BIT], 2))
    else $error("bypass not following mode");
  rx_bypass_a: assert property (rxFifoWrite |-> hdlcBypass)
    else $error("fifo write outside transparent");
  rx_pulse_a: assert property (rxFifoWrite |=> !rxFifoWrite)
    else $error("fifo write too long");
  plain_offset_a: assert property (read && ctlAck && readdata[MATCH_FOUND_BIT] &&
      !readdata[MATCH_EN_BIT] |-> readdata[2:0] == BYTE_ALIGNED)
    else $error("offset not aligned");
  tx_pop_a: assert property (txFifoRead |-> !$past(txFifoEmpty) && hdlcBypass)
    else $error("pop of empty fifo");
endmodule // dlt_tm_monitor
bind dlt_transparent_match dlt_tm_monitor dlt_tm_monitor_inst (.*);

// File: testbench/dlt_far_end.sv
// far end data link: receive bit source and transmit bit clock
`timescale 1ns/1ps
module dlt_far_end (
  input  wire logic clk,
  input  wire logic txRun,
  output      logic rxClkPin,
  output      logic rxDataPin,
  output      logic txClkPin
);
  logic [3:0] txDiv;
  initial begin
    {rxClkPin, rxDataPin, txClkPin, txDiv} = 7'h00;
  end
  // levels held well past the block's three-flop sync
  task automatic sendBits(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) rxDataPin <= v[i];
      repeat (4) @(posedge clk);
      rxClkPin <= 1'b1;
      repeat (4) @(posedge clk);
      rxClkPin <= 1'b0;
    end
    @(posedge clk) rxDataPin <= ~v[n-1];
  endtask
  always @(posedge clk) begin
    if (txRun) txDiv <= (txDiv == 4'h9) ? 4'h0 : txDiv + 4'h1;
    if (txRun && txDiv == 4'h9) txClkPin <= ~txClkPin;
  end
endmodule // dlt_far_end

// File: testbench/testbench.sv
// self-checking bench for the transparent match block
`timescale 1ns/1ps
module testbench;
  import dlt_pkg::*;
  logic        clk = 0, reset_n = 0, read = 0, write = 0, txFifoEmpty = 1, txRun = 0;
  logic [5:0]  address = 6'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata, seed = 32'h0001_08EE;
  logic [7:0]  txFifoData = 8'h00, rxFifoData, x;
  logic        waitrequest, rxClkPin, rxDataPin, txClkPin, txDataPin;
  logic        rxFifoWrite, txFifoRead, hdlcBypass;
  logic [15:0] rdQ[$], fifoQ[$];
  int          failures = 0, cmpCount = 0;
  always #50 clk = ~clk;
  dlt_far_end dlt_far_end_inst (.clk, .txRun, .rxClkPin, .rxDataPin, .txClkPin);
  dlt_transparent_match dlt_transparent_match_inst (.clk, .reset_n, .address, .read,
    .write, .writedata, .byteenable(4'hF), .readdata, .waitrequest, .rxClkPin,
    .rxDataPin, .txClkPin, .txDataPin, .rxFifoData, .rxFifoWrite, .txFifoData,
    .txFifoEmpty, .txFifoRead, .hdlcBypass);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h8020_0003 : s >> 1;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmpCount++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    // an expected result that never showed up is a miss too
    failures += rdQ.size() + fifoQ.size();
    $display("comparisons %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= {i, 2'h0};
    writedata <= {24'h00_0000, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    rdQ.push_back({8'h00, e});
    bus(0, i, 8'h00);
  endtask
  task automatic arm(input logic [7:0] c);
    bus(1, REG_LINK_CONTROL, 8'h00);
    bus(1, REG_TRANSP_CONTROL, c);
    bus(1, REG_LINK_CONTROL, 8'h04);
  endtask
  task automatic rx(input logic [15:0] v, input int n);
    dlt_far_end_inst.sendBits(v, n);
  endtask
  task automatic txChk(input logic [7:0] idle);
    logic [15:0] w;
    seed = lfsr(seed);
    txRun <= 1'b1;
    txFifoData <= seed[7:0];
    txFifoEmpty <= 1'b0;
    do @(posedge clk); while (txFifoRead !== 1'b1);
    txFifoEmpty <= 1'b1;
    repeat (16) begin
      @(negedge txClkPin);
      w = {txDataPin, w[15:1]};
    end
    chk("txDataPin", {idle, txFifoData}, w);
    txRun <= 1'b0;
  endtask
  // pre-edge values: this is the acknowledge or write edge itself
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0)
      chk("readdata", rdQ.size() ? rdQ.pop_front() : 16'hDEAD, readdata[15:0]);
    if (rxFifoWrite === 1'b1)
      chk("rxFifoData", fifoQ.size() ? fifoQ.pop_front() : 16'hDEAD, {8'h00, rxFifoData});
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(REG_RX_MATCH_CHAR, MATCH_CHAR_RESET);
    rd(REG_TX_IDLE_CHAR, IDLE_CHAR_RESET);
    rd(REG_TRANSP_CONTROL, 8'h00);
    rd(4'h0, 8'h00);
    seed = lfsr(seed);
    x = seed[7:0];
    bus(1, REG_TX_IDLE_CHAR, x);
    rd(REG_TX_IDLE_CHAR, x);
    arm(8'h40);
    fifoQ.push_back(16'h00A5);
    rx(16'h00A5, 8);
    rd(REG_TRANSP_CONTROL, 8'h4F);
    bus(1, REG_LINK_CONTROL, 8'h00);
    rd(REG_TRANSP_CONTROL, 8'h40);
    arm(8'h60);
    fifoQ.push_back(16'h007E);
    fifoQ.push_back(16'h003C);
    rx(16'h0000, 3);
    rx(16'h3C7E, 16);
    rd(REG_TRANSP_CONTROL, 8'h6A);
    arm(8'h70);
    fifoQ.push_back(16'h007E);
    rx(16'h0000, 3);
    rx(16'h3C7E, 16);
    rx(16'h0000, 5);
    rx(16'h007E, 8);
    rd(REG_TRANSP_CONTROL, 8'h7F);
    arm(8'h20);
    rx(16'h007E, 8);
    rd(REG_TRANSP_CONTROL, 8'h20);
    bus(1, REG_TRANSP_CONTROL, 8'h60);
    txChk(x);
    bus(1, REG_TRANSP_CONTROL, 8'h40);
    txChk(ONES_IDLE);
    @(posedge clk);
    final_report;
  end
endmodule // testbench
